// ---- bench/fcc_cache_tb.sv ----
/*
 * Self-checking bench of the flash read cache: APB register tasks, a
 * master transfer task and a flash model on the far side.
 * Assumes one 25 MHz clock and the package register map.
 */
`timescale 1ns/100ps
module fcc_cache_tb
   import fcc_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        err_inj, scr_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, last_wdata, scratch;
   fcc_req_t    mst_req, fl_req;
   fcc_rsp_t    mst_rsp, fl_rsp;
   logic [3:0]  lat;
   logic [7:0]  gen;
   int          rd_count, wr_count, bad_count, compares, i;

   always #20 pclk = ~pclk;

   fcc_cache fcc_cache_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mst_req(mst_req), .mst_rsp(mst_rsp),
      .fl_req(fl_req), .fl_rsp(fl_rsp), .irq(irq));

   fcc_flash_model fcc_flash_model_i (
      .pclk(pclk), .presetn(presetn), .fl_req(fl_req), .fl_rsp(fl_rsp),
      .lat(lat), .gen(gen), .err_inj(err_inj), .rd_count(rd_count), .wr_count(wr_count),
      .last_wdata(last_wdata));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] fdat(input logic [31:0] a, input logic [7:0] g);
      return a ^ {g, 24'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int t;
      t = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) chk("pready", 32'h0, 32'h1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic ee,
                        input string nm);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(nm, rd, exp);
      chk("pslverr", {31'h0, er}, {31'h0, ee});
   endtask

   task automatic irqchk(input logic exp);
      repeat (2) @(posedge pclk);
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask

   // Master transfer; nr/nw are the flash reads and writes it must cause
   task automatic mst(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [31:0] er, input logic ee, input int nr, input int nw);
      int r0, w0, t;
      r0 = rd_count;
      w0 = wr_count;
      t  = 0;
      @(posedge pclk);
      mst_req <= '{1'b1, w, a, d};
      do begin
         @(posedge pclk);
         t++;
      end while (mst_rsp.valid !== 1'b1 && t < 300);
      chk("rsp_valid", {31'h0, mst_rsp.valid}, 32'h1);
      if (!w && !ee) chk("rdata", mst_rsp.rdata, er);
      chk("rsp_err", {31'h0, mst_rsp.err}, {31'h0, ee});
      mst_req.valid <= 1'b0;
      chk("fl_reads", 32'(rd_count - r0), 32'(nr));
      chk("fl_writes", 32'(wr_count - w0), 32'(nw));
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      #800000;
      bad_count++;
      tally_and_finish;
   end

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 8'h0; pwdata = 32'h0; mst_req = '0; lat = 4'h0; gen = 8'h11;
      bad_count = 0; compares = 0;
      err_inj = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(FCC_CTL_OFS, 32'h1 << FCC_EN_BIT, 1'b0, "ctl_reset");
      rdchk(FCC_CMD_OFS, 32'h0, 1'b0, "cmd_reset");
      rdchk(FCC_MASK_OFS, 32'h0, 1'b0, "mask_reset");
      rdchk(8'h10, 32'h0, 1'b1, "unmapped");
      mst(1'b0, 32'h108, 32'h0, fdat(32'h108, gen), 1'b0, 4, 0);
      for (i = 0; i < 4; i++) begin
         mst(1'b0, 32'h100 + 4 * i, 32'h0, fdat(32'h100 + 4 * i, gen), 1'b0, 0, 0);
      end
      lat <= 4'h3;
      mst(1'b0, 32'h11c, 32'h0, fdat(32'h11c, gen), 1'b0, 4, 0);
      mst(1'b0, 32'h110, 32'h0, fdat(32'h110, gen), 1'b0, 0, 0);
      mst(1'b0, 32'h140, 32'h0, fdat(32'h140, gen), 1'b0, 4, 0);
      mst(1'b0, 32'h100, 32'h0, fdat(32'h100, gen), 1'b0, 4, 0);
      // Refused write raises the error event
      wr(FCC_MASK_OFS, 32'h1 << FCC_EV_WERR);
      mst(1'b1, 32'h104, 32'hdead_beef, 32'h0, 1'b1, 0, 0);
      irqchk(1'b1);
      rdchk(FCC_STAT_OFS, 32'h1 << FCC_EV_WERR, 1'b0, "stat_werr");
      wr(FCC_STAT_OFS, 32'h1 << FCC_EV_WERR);
      irqchk(1'b0);
      // Allowed writes pass to flash and allocate nothing
      wr(FCC_CTL_OFS, (32'h1 << FCC_EN_BIT) | (32'h1 << FCC_PROG_BIT));
      mst(1'b1, 32'h104, 32'hcafe_f00d, 32'h0, 1'b0, 0, 1);
      chk("flash_wdata", last_wdata, 32'hcafe_f00d);
      mst(1'b0, 32'h104, 32'h0, fdat(32'h104, gen), 1'b0, 0, 0);
      mst(1'b1, 32'h200, 32'h1234_5678, 32'h0, 1'b0, 0, 1);
      mst(1'b0, 32'h200, 32'h0, fdat(32'h200, gen), 1'b0, 4, 0);
      // Reprogram, stale hit, then invalidate
      gen <= 8'h22;
      mst(1'b0, 32'h110, 32'h0, fdat(32'h110, 8'h11), 1'b0, 0, 0);
      wr(FCC_CMD_OFS, 32'h1 << FCC_INV_BIT);
      i = 0;
      do begin
         apb(1'b0, FCC_CMD_OFS, 32'h0, scratch, scr_err);
         i++;
      end while (scratch[FCC_INV_BIT] !== 1'b0 && i < 20);
      chk("inv_clear", scratch, 32'h0);
      chk("inv_poll_err", {31'h0, scr_err}, 32'h0);
      rdchk(FCC_STAT_OFS, 32'h1 << FCC_EV_INV, 1'b0, "stat_inv");
      irqchk(1'b0);
      wr(FCC_MASK_OFS, 32'h1 << FCC_EV_INV);
      irqchk(1'b1);
      wr(FCC_STAT_OFS, 32'h1 << FCC_EV_INV);
      irqchk(1'b0);
      mst(1'b0, 32'h110, 32'h0, fdat(32'h110, 8'h22), 1'b0, 4, 0);
      mst(1'b0, 32'h200, 32'h0, fdat(32'h200, 8'h22), 1'b0, 4, 0);
      // Disabled: every read goes to flash
      wr(FCC_CTL_OFS, 32'h0);
      for (i = 0; i < 2; i++) begin
         mst(1'b0, 32'h100, 32'h0, fdat(32'h100, 8'h22), 1'b0, 1, 0);
      end
      gen <= 8'h33;
      wr(FCC_CTL_OFS, 32'h1 << FCC_EN_BIT);
      mst(1'b0, 32'h200, 32'h0, fdat(32'h200, 8'h33), 1'b0, 4, 0);
      // Read issued while invalidation runs must not hit
      lat <= 4'h0;
      gen <= 8'h44;
      wr(FCC_CMD_OFS, 32'h1 << FCC_INV_BIT);
      mst(1'b0, 32'h200, 32'h0, fdat(32'h200, 8'h44), 1'b0, 4, 0);
      // Flash errors are passed on and leave no valid line behind
      wr(FCC_CTL_OFS, (32'h1 << FCC_EN_BIT) | (32'h1 << FCC_PROG_BIT));
      err_inj <= 1'b1;
      mst(1'b1, 32'h104, 32'h5a5a_a5a5, 32'h0, 1'b1, 0, 1);
      mst(1'b0, 32'h300, 32'h0, 32'h0, 1'b1, 1, 0);
      err_inj <= 1'b0;
      mst(1'b0, 32'h300, 32'h0, fdat(32'h300, 8'h44), 1'b0, 4, 0);
      mst(1'b0, 32'h304, 32'h0, fdat(32'h304, 8'h44), 1'b0, 0, 0);
      rdchk(FCC_STAT_OFS, (32'h1 << FCC_EV_INV) | (32'h1 << FCC_EV_WERR),
            1'b0, "stat_ferr");
      tally_and_finish;
   end
endmodule

// ---- bench/fcc_flash_model.sv ----
/*
 * Behavioural flash behind the read cache: answers each request with one
 * valid pulse after a programmable wait, counting reads and writes.
 * Assumes the cache holds fl_req until the answer pulse.
 */
`timescale 1ns/100ps
module fcc_flash_model
   import fcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire fcc_req_t    fl_req,
   output fcc_rsp_t         fl_rsp,
   input  wire logic [3:0]  lat,
   input  wire logic [7:0]  gen,
   input  wire logic        err_inj,
   output int               rd_count,
   output int               wr_count,
   output logic      [31:0] last_wdata
);
   // ----------------------------------------------------------------
   // Answer engine
   // ----------------------------------------------------------------
   logic [3:0] wait_reg;

   // Contents follow gen, so bumping gen stands for reprogramming.
   // Between answers the data bus toggles so stale values never match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_rsp     <= '0;
         wait_reg   <= 4'h0;
         rd_count   <= 0;
         wr_count   <= 0;
         last_wdata <= 32'h0;
      end else begin
         fl_rsp.valid <= 1'b0;
         fl_rsp.err   <= 1'b0;
         fl_rsp.rdata <= ~fl_rsp.rdata;
         // Guard on the pulse: the request seen at the answer edge is old
         if (fl_req.valid && !fl_rsp.valid) begin
            if (wait_reg == lat) begin
               wait_reg     <= 4'h0;
               fl_rsp.valid <= 1'b1;
               // Error injection marks every answer while it is high
               fl_rsp.err   <= err_inj;
               if (fl_req.write) begin
                  wr_count   <= wr_count + 1;
                  last_wdata <= fl_req.wdata;
               end else begin
                  rd_count     <= rd_count + 1;
                  fl_rsp.rdata <= fl_req.addr ^ {gen, 24'h0};
               end
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end
      end
   end
endmodule

// ---- logic/fcc_cache.sv ----
/*
 * Flash read cache: direct-mapped read cache between a bus master and
 * flash, with an APB register slave and one level interrupt.
 * Assumes the master and flash hold a request until its answer pulse.
 */
// Our own choices: the placing of the registers and the APB slave port.
// Notes on behaviour
// - Read hit answered from cache, no flash.
// - Read miss refills 16-byte line from flash.
// - Refilled line hits on later reads.
// - Writes bypass cache, never allocated.
// - Unsequenced flash write answered with access error.
// - Writing one starts invalidate of all lines.
// - Invalidate bit self-clears when finished.
// - Cache enable bit, one after reset.
// - Disable then enable invalidates all lines.
`timescale 1ns/100ps
module fcc_cache
   import fcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire fcc_req_t    mst_req,
   output fcc_rsp_t         mst_rsp,
   output fcc_req_t         fl_req,
   input  wire fcc_rsp_t    fl_rsp,
   output logic             irq
);
   typedef enum {ST_IDLE, ST_FILL, ST_PASS, ST_INV} fcc_state_t;

   fcc_state_t             state_reg;
   fcc_req_t               cur_reg;
   fcc_rsp_t               rsp_reg;
   fcc_req_t               flq_reg;
   logic [FCC_IDX_W-1:0]   fill_cnt_reg;
   logic [FCC_IDX_W-1:0]   inv_cnt_reg;
   logic                   cache_on_reg;
   logic                   prog_en_reg;
   logic                   cmd_inv_reg;
   logic [FCC_EV_W-1:0]    stat_reg;
   logic [FCC_EV_W-1:0]    stat_next;
   logic [FCC_EV_W-1:0]    mask_reg;
   logic [FCC_EV_W-1:0]    ev;
   logic [31:0]            prdata_reg;
   logic                   pready_reg;
   logic                   pslverr_reg;
   logic                   irq_reg;
   logic [FCC_LINES-1:0]   valid_vec;
   logic [FCC_TAG_W-1:0]   tag_arr  [FCC_LINES];
   logic [31:0]            data_arr [FCC_LINES][FCC_WORDS];
   logic [FCC_IDX_W-1:0]   req_idx;
   logic [FCC_IDX_W-1:0]   req_wsel;
   logic [FCC_IDX_W-1:0]   cur_idx;
   logic [FCC_IDX_W-1:0]   cur_wsel;
   logic                   hit;
   logic                   acc;
   logic                   fill_beat;
   logic                   fill_last;
   logic                   inv_last;
   logic                   apb_wr;
   logic                   apb_setup;
   logic                   inv_set;

   // ----------------------------------------------------------------
   // Lookup
   // ----------------------------------------------------------------
   assign req_idx   = mst_req.addr[FCC_IDX_LSB +: FCC_IDX_W];
   assign req_wsel  = mst_req.addr[FCC_WSEL_LSB +: FCC_IDX_W];
   assign cur_idx   = cur_reg.addr[FCC_IDX_LSB +: FCC_IDX_W];
   assign cur_wsel  = cur_reg.addr[FCC_WSEL_LSB +: FCC_IDX_W];
   // A request is taken once; the guard on rsp_reg skips the cycle in
   // which the master still holds the request just answered.
   // stall while invalidating
   assign acc       = state_reg == ST_IDLE && !cmd_inv_reg && mst_req.valid && !rsp_reg.valid;
   assign hit       = cache_on_reg && valid_vec[req_idx]
                      && tag_arr[req_idx] == mst_req.addr[31:FCC_TAG_LSB];
   assign fill_beat = state_reg == ST_FILL && fl_rsp.valid && !fl_rsp.err;
   assign fill_last = fill_beat && fill_cnt_reg == FCC_IDX_W'(FCC_WORDS - 1);
   assign inv_last  = state_reg == ST_INV && inv_cnt_reg == FCC_IDX_W'(FCC_LINES - 1);

   // ----------------------------------------------------------------
   // Line storage
   // ----------------------------------------------------------------
   for (genvar g = 0; g < FCC_LINES; g++) begin : g_line
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            valid_vec[g] <= 1'b0;
         end else if (state_reg == ST_INV && inv_cnt_reg == FCC_IDX_W'(g)) begin
            valid_vec[g] <= 1'b0;
         end else if (fill_last && cur_idx == FCC_IDX_W'(g)) begin
            valid_vec[g] <= 1'b1;
         // a half-refilled line must never hit after a flash error
         end else if (fill_beat && cur_idx == FCC_IDX_W'(g)) begin
            valid_vec[g] <= 1'b0;
         end
      end
      always_ff @(posedge pclk) begin
         if (fill_beat && cur_idx == FCC_IDX_W'(g)) begin
            data_arr[g][fill_cnt_reg] <= fl_rsp.rdata;
            tag_arr[g]                <= cur_reg.addr[31:FCC_TAG_LSB];
         end
      end
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_IDLE;
         cur_reg      <= '0;
         rsp_reg      <= '0;
         flq_reg      <= '0;
         fill_cnt_reg <= '0;
         inv_cnt_reg  <= '0;
      end else begin
         rsp_reg.valid <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (cmd_inv_reg) begin
                  state_reg   <= ST_INV;
                  inv_cnt_reg <= '0;
               end else if (acc) begin
                  cur_reg <= mst_req;
                  if (mst_req.write) begin
                     if (prog_en_reg) begin
                        flq_reg   <= mst_req;
                        state_reg <= ST_PASS;
                     end else begin
                        rsp_reg <= '{valid: 1'b1, err: 1'b1, rdata: 32'h0000_0000};
                     end
                  end else if (hit) begin
                     rsp_reg <= '{valid: 1'b1, err: 1'b0,
                                  rdata: data_arr[req_idx][req_wsel]};
                  end else if (!cache_on_reg) begin
                     flq_reg   <= mst_req;
                     state_reg <= ST_PASS;
                  end else begin
                     flq_reg   <= '{valid: 1'b1, write: 1'b0, wdata: 32'h0000_0000,
                                    addr: {mst_req.addr[31:FCC_IDX_LSB], 4'h0}};
                     fill_cnt_reg <= '0;
                     state_reg    <= ST_FILL;
                  end
               end
            end
            ST_FILL: begin
               if (fl_rsp.valid && fl_rsp.err) begin
                  flq_reg.valid <= 1'b0;
                  rsp_reg       <= '{valid: 1'b1, err: 1'b1, rdata: 32'h0000_0000};
                  state_reg     <= ST_IDLE;
               end else if (fill_last) begin
                  // requested word returned with the last beat
                  flq_reg.valid <= 1'b0;
                  rsp_reg       <= '{valid: 1'b1, err: 1'b0,
                                     rdata: (cur_wsel == fill_cnt_reg) ? fl_rsp.rdata
                                                                      : data_arr[cur_idx][cur_wsel]};
                  state_reg     <= ST_IDLE;
               end else if (fill_beat) begin
                  fill_cnt_reg <= fill_cnt_reg + 1'b1;
                  flq_reg.addr <= {cur_reg.addr[31:FCC_IDX_LSB], fill_cnt_reg + 1'b1, 2'b00};
               end
            end
            ST_PASS: begin
               if (fl_rsp.valid) begin
                  flq_reg.valid <= 1'b0;
                  rsp_reg       <= '{valid: 1'b1, err: fl_rsp.err, rdata: fl_rsp.rdata};
                  state_reg     <= ST_IDLE;
               end
            end
            ST_INV: begin
               inv_cnt_reg <= inv_cnt_reg + 1'b1;
               if (inv_last) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite && pready_reg;
   assign inv_set   = (apb_wr && paddr == FCC_CMD_OFS && pwdata[FCC_INV_BIT])
                      || (apb_wr && paddr == FCC_CTL_OFS && pwdata[FCC_EN_BIT] && !cache_on_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= apb_setup && !(paddr inside {FCC_CMD_OFS, FCC_CTL_OFS,
                                                     FCC_STAT_OFS, FCC_MASK_OFS});
         if (apb_setup) begin
            unique case (paddr)
               FCC_CMD_OFS:  prdata_reg <= {31'h0, cmd_inv_reg};
               FCC_CTL_OFS:  prdata_reg <= {30'h0, prog_en_reg, cache_on_reg};
               FCC_STAT_OFS: prdata_reg <= {30'h0, stat_reg};
               FCC_MASK_OFS: prdata_reg <= {30'h0, mask_reg};
               default:      prdata_reg <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_on_reg <= FCC_EN_RST;
         prog_en_reg  <= FCC_PROG_RST;
         mask_reg     <= '0;
      end else if (apb_wr && paddr == FCC_CTL_OFS) begin
         cache_on_reg <= pwdata[FCC_EN_BIT];
         prog_en_reg  <= pwdata[FCC_PROG_BIT];
      end else if (apb_wr && paddr == FCC_MASK_OFS) begin
         mask_reg <= pwdata[FCC_EV_W-1:0];
      end
   end

   // A new request in the finishing cycle wins, so it is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_inv_reg <= 1'b0;
      // start on command; re-enable restarts invalidation
      end else if (inv_set) begin
         cmd_inv_reg <= 1'b1;
      end else if (inv_last) begin
         cmd_inv_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   always_comb begin
      ev                = '0;
      ev[FCC_EV_INV]    = inv_last && !inv_set;
      ev[FCC_EV_WERR]   = (acc && mst_req.write && !prog_en_reg)
                          || (state_reg == ST_PASS && fl_rsp.valid && fl_rsp.err && cur_reg.write);
      stat_next         = stat_reg;
      if (apb_wr && paddr == FCC_STAT_OFS) begin
         stat_next = stat_reg & ~pwdata[FCC_EV_W-1:0];
      end
      stat_next = stat_next | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= '0;
         irq_reg  <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         irq_reg  <= |(stat_next & mask_reg);
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign mst_rsp = rsp_reg;
   assign fl_req  = flq_reg;
   assign irq     = irq_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_read_take;
      acc && !mst_req.write;
   endsequence
   sequence seq_answer_now;
      rsp_reg.valid && !flq_reg.valid;
   endsequence

   chk_hit_no_flash: assert property (
      seq_read_take and hit |=> seq_answer_now and state_reg == ST_IDLE)
      else $error("hit did not answer from storage");
   chk_miss_refill: assert property (
      seq_read_take and cache_on_reg && !hit
      |=> state_reg == ST_FILL && flq_reg.valid && flq_reg.addr[3:0] == 4'h0)
      else $error("miss did not start line refill");
   chk_fill_valid: assert property (
      fill_last |=> valid_vec[$past(cur_idx)] && rsp_reg.valid && !rsp_reg.err)
      else $error("refilled line not valid");
   chk_write_bypass: assert property (
      acc && mst_req.write && prog_en_reg
      |=> state_reg == ST_PASS && flq_reg.write && $stable(valid_vec))
      else $error("write not bypassed to flash");
   chk_write_error: assert property (
      acc && mst_req.write && !prog_en_reg |=> rsp_reg.valid && rsp_reg.err && stat_reg[FCC_EV_WERR])
      else $error("unsequenced write not refused");
   chk_inv_start: assert property (
      inv_set |=> cmd_inv_reg)
      else $error("invalidate command lost");
   chk_inv_finish: assert property (
      inv_last && !inv_set |=> !cmd_inv_reg && valid_vec == '0)
      else $error("invalidate did not complete");
   chk_enable_write: assert property (
      apb_wr && paddr == FCC_CTL_OFS |=> cache_on_reg == $past(pwdata[FCC_EN_BIT]))
      else $error("enable bit not updated");
   chk_reenable_inv: assert property (
      $rose(cache_on_reg) |-> cmd_inv_reg)
      else $error("re-enable did not invalidate");
   chk_off_bypass: assert property (
      seq_read_take and !cache_on_reg |=> state_reg == ST_PASS && $stable(valid_vec))
      else $error("disabled read not passed to flash");
   chk_inv_stall: assert property (
      cmd_inv_reg && state_reg == ST_IDLE |=> state_reg == ST_INV && !rsp_reg.valid)
      else $error("read taken during invalidation");
endmodule

// ---- pkg/fcc_pkg.sv ----
/*
 * Shared constants and carrier types of the flash read cache.
 * Assumes one clock domain and a 32-bit APB register port.
 */
package fcc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  FCC_CMD_OFS  = 8'h00;
   localparam logic [7:0]  FCC_CTL_OFS  = 8'h04;
   localparam logic [7:0]  FCC_STAT_OFS = 8'h08;
   localparam logic [7:0]  FCC_MASK_OFS = 8'h0c;
   localparam int          FCC_INV_BIT  = 0;
   localparam int          FCC_EN_BIT   = 0;
   localparam int          FCC_PROG_BIT = 1;
   localparam int          FCC_EV_INV   = 0;
   localparam int          FCC_EV_WERR  = 1;
   localparam int          FCC_EV_W     = 2;
   localparam logic        FCC_EN_RST   = 1'b1;
   localparam logic        FCC_PROG_RST = 1'b0;
   // ----------------------------------------------------------------
   // Cache geometry: 4 lines of 16 bytes, direct mapped
   // ----------------------------------------------------------------
   localparam int          FCC_LINES    = 4;
   localparam int          FCC_WORDS    = 4;
   localparam int          FCC_IDX_W    = 2;
   localparam int          FCC_WSEL_LSB = 2;
   localparam int          FCC_IDX_LSB  = 4;
   localparam int          FCC_TAG_LSB  = 6;
   localparam int          FCC_TAG_W    = 32 - FCC_TAG_LSB;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } fcc_req_t;
   typedef struct packed {
      logic        valid;
      logic        err;
      logic [31:0] rdata;
   } fcc_rsp_t;
endpackage
